// ---- rtl/hotplug_event_signalling.sv ----
// Purpose: per-port hot-plug notification routing (irq, wake, gp event)
// Assumes: slot status set and cleared by the slot logic; inputs synchronous
// Notes:   msi and pme requests are one-cycle pulses on each new unmasked event, intx is a level
`timescale 1ns/1ps
`default_nettype none
// Operation
// - interrupts only with hot-plug irq enable
// - five status flags request unless masked
// - msi or legacy chosen from command bits
// - D3hot, irq disabled: wake only
// - D3hot, irq enabled: wake and irq
// - masked event: no wake, no irq
// - command completed never wakes
// - gp event mode replaces irq, msi, wake
// - gp event reaches pin7 only in alternate
// - gp event signalled sets status bit
// - gp status set only in gp mode
// - status and mask behave as standard
// - non-hotplug sources unaffected by gp mode
// - outputs cleared during reset, pin7 undriven
// - slot sensors via external expanders
// - eeprom load never sets command completed
module hotplug_event_signalling #(
    parameter int NUM_PORTS = 2
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // slot state per port, from expander-fed slot logic
    input  wire logic [NUM_PORTS*5-1:0] slot_status,
    input  wire logic [NUM_PORTS*5-1:0] slot_control,
    input  wire logic [NUM_PORTS-1:0] hotplug_irq_enable,
    input  wire logic [NUM_PORTS-1:0] msi_enable,
    input  wire logic [NUM_PORTS-1:0] legacy_irq_disable,
    input  wire logic [NUM_PORTS-1:0] port_d3hot,
    input  wire logic                 switch_d3hot,
    input  wire logic                 eeprom_loading,
    // other interrupt sources per port
    input  wire logic [NUM_PORTS-1:0] other_msi_req,
    input  wire logic [NUM_PORTS-1:0] other_intx_req,
    input  wire logic [NUM_PORTS-1:0] other_pme_req,
    // legacy gp event
    input  wire logic [NUM_PORTS-1:0] gp_event_control,
    input  wire logic [NUM_PORTS-1:0] gp_status_clear,
    input  wire logic                 pin7_mode,
    // notifications
    output logic [NUM_PORTS-1:0]      msi_req,
    output logic [NUM_PORTS-1:0]      intx_assert,
    output logic [NUM_PORTS-1:0]      pme_req,
    output logic [NUM_PORTS-1:0]      gp_event_status,
    output logic                      gp_event_out,
    output logic                      pin7_out,
    output logic                      pin7_oe
);
    localparam int NE = hotplug_event_pkg::NUM_EVENTS;
    localparam int NW = NUM_PORTS * NE;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // slot vectors must carry exactly one flag set a port
    generate
        if (NUM_PORTS < 1) begin : g_bad_ports
            $error("NUM_PORTS must be at least one");
        end
        if ($bits(slot_status) != NW) begin : g_bad_status
            $error("slot status width does not match the event count");
        end
        if ($bits(slot_control) != NW) begin : g_bad_control
            $error("slot control width does not match the event count");
        end
        if (hotplug_event_pkg::EV_CMDDONE >= NE) begin : g_bad_cmddone
            $error("command completed position outside the flag set");
        end
    endgenerate

    // ------------------------------------------------------------
    // load gating
    // ------------------------------------------------------------
    logic [NE-1:0] cmdDoneLane;
    logic [NE-1:0] loadGate;

    assign cmdDoneLane = NE'(1) << hotplug_event_pkg::EV_CMDDONE;

    // gate during load
    // only the command completed lane is blanked, other flags still count
    assign loadGate = eeprom_loading ? ~cmdDoneLane : '1;

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic [NW-1:0]        prevStatus;
    logic [NUM_PORTS-1:0] anyEvent;
    logic [NUM_PORTS-1:0] irqEvent;
    logic [NUM_PORTS-1:0] wakeEvent;
    logic [NUM_PORTS-1:0] pendingIrq;

    // history kept ungated, so the end of a load makes no false edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prevStatus <= '0;
        end else begin
            prevStatus <= slot_status;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [NE-1:0] stat;
            logic [NE-1:0] prev;
            logic [NE-1:0] mask;
            logic [NE-1:0] rise;
            logic [NE-1:0] unmasked;
            logic [NE-1:0] wakeable;
            logic [NE-1:0] levelOn;
            logic          d3;

            assign stat = slot_status[p*NE +: NE];
            assign prev = prevStatus[p*NE +: NE];
            assign mask = slot_control[p*NE +: NE];

            // new flags only, a held flag asks once
            assign rise = stat & ~prev & loadGate;

            assign unmasked = rise & mask;

            assign wakeable = unmasked & hotplug_event_pkg::WAKE_CAPABLE;

            assign levelOn = stat & loadGate & mask;

            // port or whole switch asleep
            assign d3 = port_d3hot[p] | switch_d3hot;

            assign anyEvent[p] = |unmasked;

            assign irqEvent[p] = anyEvent[p] & hotplug_irq_enable[p];

            assign wakeEvent[p] = d3 & (|wakeable);

            // level source for legacy interrupt
            assign pendingIrq[p] = hotplug_irq_enable[p] & (|levelOn);
        end
    endgenerate

    // ------------------------------------------------------------
    // notification form
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] pcieMode;
    logic [NUM_PORTS-1:0] hpMsi;
    logic [NUM_PORTS-1:0] hpIntx;
    logic [NUM_PORTS-1:0] hpPme;

    assign pcieMode = ~gp_event_control;

    assign hpMsi = irqEvent & pcieMode & msi_enable;
    assign hpIntx = pendingIrq & pcieMode & ~msi_enable & ~legacy_irq_disable;

    assign hpPme = wakeEvent & pcieMode;

    // ------------------------------------------------------------
    // pcie notifications
    // ------------------------------------------------------------
    // other sources pass through
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            msi_req <= '0;
        end else begin
            msi_req <= hpMsi | other_msi_req;
        end
    end

    // intx is a level, it stands while an unmasked flag is set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            intx_assert <= '0;
        end else begin
            intx_assert <= hpIntx | other_intx_req;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pme_req <= '0;
        end else begin
            pme_req <= hpPme | other_pme_req;
        end
    end

    // ------------------------------------------------------------
    // gp event path
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] gpEvent;
    logic [NUM_PORTS-1:0] next_gpStatus;
    logic                 gpAny;
    logic                 altMode;

    // any unmasked edge, irq enable and power state aside
    assign gpEvent = gp_event_control & anyEvent;

    // only ports in gp mode
    // set wins over a same-cycle clear, so no event is lost
    assign next_gpStatus = (gp_event_status & ~gp_status_clear) | gpEvent;
    assign gpAny = |next_gpStatus;
    assign altMode = (pin7_mode == hotplug_event_pkg::PIN_ALT_FUNC);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gp_event_status <= '0;
        end else begin
            gp_event_status <= next_gpStatus;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gp_event_out <= 1'h0;
        end else begin
            gp_event_out <= gpAny;
        end
    end

    // pin driven only in alternate mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin7_out <= 1'h0;
            pin7_oe <= 1'h0;
        end else begin
            pin7_out <= altMode & gpAny;
            pin7_oe <= altMode;
        end
    end
    // expander interface lives upstream of slot_status
endmodule
`default_nettype wire

// ---- rtl/hotplug_event_pkg.sv ----
// Purpose: shared constants for hot-plug event signalling
// Assumes: two downstream ports by default
// Notes:   slot event bit order is fixed here
package hotplug_event_pkg;
    localparam int NUM_EVENTS  = 5;
    localparam int EV_ATTN     = 0;
    localparam int EV_PFAULT   = 1;
    localparam int EV_LATCH    = 2;
    localparam int EV_PRESENCE = 3;
    localparam int EV_CMDDONE  = 4;
    // events that may wake the link; command completed never does
    localparam logic [4:0] WAKE_CAPABLE = 5'h0F;
    localparam logic       PIN_ALT_FUNC = 1'h1;
endpackage

// ---- testbench/hotplug_event_sva.sv ----
// Purpose: port 0 notification checks
// Assumes: other sources and switch D3hot idle
// Notes:   port 1 unwatched
`timescale 1ns/1ps
`default_nettype none
module hotplug_event_sva #(parameter int NUM_PORTS = 2) (
    // watched ports
    input wire logic [NUM_PORTS*5-1:0] slot_status, slot_control,
    input wire logic [NUM_PORTS-1:0]   hotplug_irq_enable, msi_enable, port_d3hot,
    input wire logic [NUM_PORTS-1:0]   gp_event_control, msi_req, pme_req, gp_event_status,
    input wire logic                   clock, rst_n, gp_event_out, pin7_out, pin7_oe
);
    logic [4:0] prev;
    wire logic [4:0] rise = slot_status[4:0] & ~prev & slot_control[4:0];
    wire logic gp = gp_event_control[0];
    wire logic ok = hotplug_irq_enable[0] & msi_enable[0] & ~gp;
    wire logic wake = |(rise & hotplug_event_pkg::WAKE_CAPABLE) & port_d3hot[0] & ~gp;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 5'h00;
        end else begin
            prev <= slot_status[4:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_msi_event: assert property (|rise && ok |=> msi_req[0])
        else $error("msi missing");
    a_msi_cause: assert property (msi_req[0] |-> $past(|rise && ok))
        else $error("msi uncaused");
    a_wake_event: assert property (wake |=> pme_req[0])
        else $error("pme missing");
    a_wake_cause: assert property (pme_req[0] |-> $past(wake))
        else $error("pme uncaused");
    a_gp_set: assert property (|rise && gp |=> gp_event_status[0])
        else $error("gp not set");
    a_gp_only: assert property ($rose(gp_event_status[0]) |-> $past(gp))
        else $error("gp set outside mode");
    a_gp_out: assert property (gp_event_out == |gp_event_status)
        else $error("gp out wrong");
    a_pin_alt: assert property (pin7_out |-> pin7_oe && gp_event_out)
        else $error("pin driven wrongly");
endmodule
bind hotplug_event_signalling hotplug_event_sva #(.NUM_PORTS(NUM_PORTS)) i_sva (.*);
`default_nettype wire

// ---- testbench/root_model.sv ----
// Purpose: root side tally of messages
// Assumes: requests are one-cycle pulses
// Notes:   accepts all, never stalls
`timescale 1ns/1ps
`default_nettype none
module root_model (
    // requests in
    input  wire logic [1:0] msi, pme,
    input  wire logic       clock,
    // tallies out
    output var int          nMsi, nPme
);
    initial {nMsi, nPme} = 0;
    always @(posedge clock) {nMsi, nPme} <= {nMsi + $countones(msi), nPme + $countones(pme)};
endmodule
`default_nettype wire

// ---- testbench/tb_hotplug_event_signalling.sv ----
// Purpose: bench for hot-plug notification routing
// Assumes: port 0 driven, port 1 idle
// Notes:   inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_hotplug_event_signalling;
    logic       clock, rst_n, mode, gOut, pOut, pOe;
    logic [9:0] st, ct;
    logic [1:0] hp, me, ld, d3, gc, clr, msi, intx, pme, gs;
    int         num_errors = 0, compares = 0, nMsi, nPme;
    hotplug_event_signalling i_dut (.clock, .rst_n, .slot_status(st), .slot_control(ct),
        .hotplug_irq_enable(hp), .msi_enable(me), .legacy_irq_disable(ld), .port_d3hot(d3),
        .switch_d3hot(1'h0), .eeprom_loading(1'h0), .other_msi_req(2'h0), .other_intx_req(2'h0),
        .other_pme_req(2'h0), .gp_event_control(gc), .gp_status_clear(clr), .pin7_mode(mode),
        .msi_req(msi), .intx_assert(intx), .pme_req(pme), .gp_event_status(gs),
        .gp_event_out(gOut), .pin7_out(pOut), .pin7_oe(pOe));
    root_model i_root (.clock, .msi, .pme, .nMsi, .nPme);
    task automatic chk(string n, logic [3:0] e, logic [3:0] g);
        compares++;
        if (e !== g) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // flag rise on port 0, then {msi, intx, pme, gp status}
    task automatic ev(int b, string n, logic [3:0] e);
        @(negedge clock) st[b] = 1'h1;
        @(posedge clock) #1 chk(n, e, {msi[0], intx[0], pme[0], gs[0]});
        @(negedge clock) st[b] = 1'h0;
    endtask
    task automatic t_irq;
        {hp, me, ct} = {2'h1, 2'h1, 10'h01F};
        ev(3, "msi", 4'h8);
        me = 2'h0;
        ev(0, "intx", 4'h4);
        ld = 2'h1;
        ev(1, "intxoff", 4'h0);
        {hp, me} = 4'h1;
        ev(2, "hpoff", 4'h0);
        $display("t_irq done");
    endtask
    task automatic t_wake;
        d3 = 2'h1;
        ev(3, "wake", 4'h2);
        {hp, me} = 4'h5;
        ev(1, "wakeirq", 4'hA);
        ev(4, "cmddone", 4'h8);
        ct = 10'h01E;
        ev(0, "masked", 4'h0);
        chk("root", 4'hE, {nMsi[1:0], nPme[1:0]});
        $display("t_wake done");
    endtask
    task automatic t_gp;
        {gc, mode} = 3'h3;
        ev(2, "gp", 4'h1);
        chk("gpout", 4'h7, {1'h0, gOut, pOut, pOe});
        @(negedge clock) clr = 2'h1;
        @(negedge clock) clr = 2'h0;
        chk("gpclr", 4'h1, {gs[0], gOut, pOut, pOe});
        {hp, d3, mode} = 5'h00;
        ev(2, "gpquiet", 4'h1);
        chk("pinoff", 4'h4, {1'h0, gOut, pOut, pOe});
        @(negedge clock) clr = 2'h1;
        @(negedge clock) clr = 2'h0;
        {hp, d3} = 4'h5;
        gc = 2'h0;
        ev(2, "nogp", 4'hA);
        $display("t_gp done");
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    initial begin
        {rst_n, mode, st, ct, hp, me, ld, d3, gc, clr} = '0;
        repeat (8) @(negedge clock);
        chk("reset", 4'h0, {pOe, gOut, msi[0], pme[0]});
        rst_n = 1'h1;
        t_irq;
        t_wake;
        t_gp;
        end_sim;
    end
endmodule
`default_nettype wire
